// ### sim/sbx_exec_monitor.sv
// Port checks for the execution unit
`timescale 1ns/1ns
module sbx_exec_monitor (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Request
  input wire logic       exec_valid_i,
  input wire logic [1:0] exec_op_i,
  input wire logic [7:0] exec_imm_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic       exec_ready_o,
  // Results
  input wire logic       mem_we_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic       skip_o,
  input wire logic       dummy_o,
  input wire logic [7:0] acc_o,
  input wire logic [5:0] flags_o
);
  logic       tk;
  logic [8:0] di;
  logic [8:0] dm;
  logic [7:0] dc;
  assign tk = exec_valid_i & exec_ready_o;
  assign di = {1'b0, acc_o} - {1'b0, exec_imm_i} - {8'h00, ~flags_o[0]};
  assign dm = {1'b0, acc_o} - {1'b0, mem_rdata_i} - {8'h00, ~flags_o[0]};
  assign dc = mem_rdata_i - 8'h01;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  imm_sub_a: assert property (tk && exec_op_i == 2'h0
    |=> acc_o == $past(di[7:0])) else $error("imm sub");
  sub_flags_a: assert property (tk && exec_op_i == 2'h0
    |=> flags_o[0] == !$past(di[8]) && flags_o[2] == (acc_o == 8'h00))
    else $error("sub flags");
  mem_sub_a: assert property (tk && exec_op_i == 2'h1
    |=> mem_we_o && mem_wdata_o == $past(dm[7:0]) && $stable(acc_o)
    && flags_o[0] == !$past(dm[8])) else $error("mem sub");
  dec_mem_a: assert property (tk && exec_op_i == 2'h2
    |=> mem_we_o && mem_wdata_o == $past(dc)
    && skip_o == ($past(dc) == 8'h00)) else $error("dec mem");
  dec_acc_a: assert property (tk && exec_op_i == 2'h3
    |=> !mem_we_o && acc_o == $past(dc) && skip_o == (acc_o == 8'h00))
    else $error("dec acc");
  no_skip_a: assert property (tk && exec_op_i[1] && dc != 8'h00
    |=> !skip_o && !dummy_o) else $error("bad skip");
  skip_dummy_a: assert property (skip_o
    |-> dummy_o && !exec_ready_o) else $error("no dummy");
  dummy_one_a: assert property (dummy_o
    |=> !dummy_o && exec_ready_o) else $error("long dummy");
endmodule
bind sbx_exec sbx_exec_monitor mon (
  .clk_i        (clk_i),
  .rst_i        (rst_i),
  .exec_valid_i (exec_valid_i),
  .exec_op_i    (exec_op_i),
  .exec_imm_i   (exec_imm_i),
  .mem_rdata_i  (mem_rdata_i),
  .exec_ready_o (exec_ready_o),
  .mem_we_o     (mem_we_o),
  .mem_wdata_o  (mem_wdata_o),
  .skip_o       (skip_o),
  .dummy_o      (dummy_o),
  .acc_o        (acc_o),
  .flags_o      (flags_o)
);

// ### sim/sbx_exec_tb_top.sv
// Directed bench for the execution unit
`timescale 1ns/1ns
module sbx_exec_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic        ack;
  logic        vld = 1'b0;
  logic [1:0]  op = 2'h0;
  logic [7:0]  imm = 8'h00;
  logic        ld = 1'b0;
  logic [7:0]  ldv = 8'h00;
  logic [7:0]  mrd, mwd, acc, rv;
  logic        mwe, rdy, skp, dmy;
  logic [5:0]  flg;
  logic [7:0]  m_acc = 8'h10;
  logic [7:0]  m_mem = 8'h00;
  logic [5:0]  m_f = 6'h01;
  int          bad_count = 0;
  int          checks_done = 0;
  initial forever #5 clk_i = ~clk_i;
  sbx_exec uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .exec_valid_i(vld),
    .exec_op_i(op), .exec_imm_i(imm), .mem_rdata_i(mrd),
    .exec_ready_o(rdy), .mem_we_o(mwe), .mem_wdata_o(mwd), .skip_o(skp),
    .dummy_o(dmy), .acc_o(acc), .flags_o(flg));
  sbx_mem_model u_mem (.clk_i(clk_i), .rst_i(rst_i), .load_i(ld),
    .load_val_i(ldv), .we_i(mwe), .wdata_i(mwd), .rdata_o(mrd));
  task automatic give_verdict;
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n > 20) begin
      bad_count++;
      give_verdict;
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
      hang(n);
    end while (ack !== 1'b1);
    rv = rd[7:0];
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ldm(input logic [7:0] v);
    ld <= 1'b1;
    ldv <= v;
    m_mem = v;
    @(posedge clk_i);
    ld <= 1'b0;
  endtask
  task automatic ex(input logic [1:0] o, input logic [7:0] i, input logic k);
    logic [8:0] r;
    logic [7:0] b;
    logic [4:0] h;
    logic v;
    logic s;
    int n;
    n = 0;
    vld <= 1'b1;
    op <= o;
    imm <= i;
    do begin
      @(posedge clk_i);
      n++;
      hang(n);
    end while (rdy !== 1'b1);
    b = o[0] ? m_mem : i;
    r = {1'b0, m_acc} - {1'b0, b} - {8'h00, ~m_f[0]};
    h = {1'b0, m_acc[3:0]} - {1'b0, b[3:0]} - {4'h0, ~m_f[0]};
    v = (m_acc[7] ^ b[7]) & (m_acc[7] ^ r[7]);
    if (!o[1]) m_f = {(r[7:0] == 8'h00) & m_f[2], v ^ r[7], v,
                      r[7:0] == 8'h00, ~h[4], ~r[8]};
    if (o[1]) r = {1'b0, m_mem - 8'h01};
    s = o[1] && r[7:0] == 8'h00;
    if (o != 2'h1) m_acc = (o == 2'h2) ? m_acc : r[7:0];
    if (o[0] != o[1]) m_mem = r[7:0];
    if (!k) vld <= 1'b0;
    @(posedge clk_i);
    chk(acc, m_acc);
    chk({2'h0, flg}, {2'h0, m_f});
    chk({6'h0, skp, dmy}, {6'h0, s, s});
    chk({7'h0, mwe}, {7'h0, o[0] ^ o[1]});
    if (o[0] != o[1]) chk(mwd, m_mem);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'hC, 8'h00);
    chk(rv, 8'h00);
    wb(1'b0, sbx_pkg::ADDR_ACC, 8'h00);
    chk(rv, sbx_pkg::ACC_RST);
    wb(1'b1, sbx_pkg::ADDR_ACC, 8'h10);
    wb(1'b1, sbx_pkg::ADDR_STATUS, 8'h01);
    ex(2'h0, 8'h05, 1'b0);
    ex(2'h0, 8'h20, 1'b0);
    ex(2'h0, 8'h00, 1'b0);
    ex(2'h0, 8'hEA, 1'b0);
    wb(1'b0, sbx_pkg::ADDR_ACC, 8'h00);
    chk(rv, m_acc);
    wb(1'b0, sbx_pkg::ADDR_STATUS, 8'h00);
    chk(rv, {2'h0, m_f});
    ldm(8'h0A);
    ex(2'h1, 8'h00, 1'b0);
    ldm(8'h02);
    ex(2'h2, 8'h00, 1'b0);
    ex(2'h2, 8'h00, 1'b1);
    ex(2'h0, 8'h01, 1'b0);
    ldm(8'h01);
    ex(2'h3, 8'h00, 1'b0);
    wb(1'b0, sbx_pkg::ADDR_INFO, 8'h00);
    chk(rv, 8'h02);
    ldm(8'h00);
    ex(2'h2, 8'h00, 1'b0);
    ex(2'h3, 8'h00, 1'b0);
    chk(mrd, m_mem);
    give_verdict;
  end
endmodule

// ### sim/sbx_mem_model.sv
// Data memory byte behind the execution unit
`timescale 1ns/1ns
module sbx_mem_model (
  // Clock, reset, preload
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_val_i,
  // Memory port
  input  wire logic       we_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) rdata_o <= 8'h00;
    else if (we_i) rdata_o <= wdata_i;
    else if (load_i) rdata_o <= load_val_i;
  end
endmodule

// ### verilog/sbx_alu.sv
// Eight-bit subtractor with borrow and flag generation
`timescale 1ns/1ns
module sbx_alu (
  sbx_alu_if.alu p
);
  logic [8:0] full;
  logic [4:0] low;
  logic       borrow;

  // ==========================================================
  // Difference a - b - not carry, two's complement
  assign borrow = ~p.carry_in;
  assign full = {1'b0, p.a} - {1'b0, p.b} - {8'h00, borrow};
  assign low  = {1'b0, p.a[3:0]} - {1'b0, p.b[3:0]} - {4'h0, borrow};
  assign p.diff       = full[7:0];
  assign p.carry_out  = ~full[8];
  assign p.half_carry = ~low[4];
  assign p.arith_wrap_flag = (p.a[7] ^ p.b[7]) & (p.a[7] ^ full[7]);
  assign p.signed_carry    = (p.a[7] ^ p.b[7]) & (p.a[7] ^ full[7])
                             ^ full[7];
endmodule

// ### verilog/sbx_alu_if.sv
// Operand and result bundle between the sequencer and the subtractor
`timescale 1ns/1ns
interface sbx_alu_if;
  logic [7:0] a;
  logic [7:0] b;
  logic       carry_in;
  logic [7:0] diff;
  logic       carry_out;
  logic       half_carry;
  logic       arith_wrap_flag;
  logic       signed_carry;

  modport seq (output a, b, carry_in,
               input  diff, carry_out, half_carry, arith_wrap_flag,
                      signed_carry);
  modport alu (input  a, b, carry_in,
               output diff, carry_out, half_carry, arith_wrap_flag,
                      signed_carry);
endinterface

// ### verilog/sbx_exec.sv
// Execution unit for subtract-with-borrow and decrement-skip instructions
`timescale 1ns/1ns
module sbx_exec (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Instruction request from decoder
  input  wire logic        exec_valid_i,
  input  wire logic [1:0]  exec_op_i,
  input  wire logic [7:0]  exec_imm_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic             exec_ready_o,
  // Data memory write and sequencer feedback
  output logic             mem_we_o,
  output logic      [7:0]  mem_wdata_o,
  output logic             skip_o,
  output logic             dummy_o,
  // Core state
  output logic      [7:0]  acc_o,
  output logic      [5:0]  flags_o
);
  typedef enum logic [0:0] {
    ST_RUN,
    ST_DUMMY
  } sbx_state_t;

  sbx_state_t       state_q;
  logic       [7:0] acc_q;
  logic       [5:0] flags_q;
  logic             last_skip_q;
  logic             mem_we_q;
  logic       [7:0] mem_wdata_q;
  logic             skip_q;
  logic             wb_ack_q;
  logic      [31:0] wb_dat_q;
  sbx_pkg::sbx_op_t op;
  logic             take;
  logic             is_sub;
  logic             zero;
  logic             wb_wr;
  logic             ready_q;
  logic             dummy_q;
  logic             skip_hit;
  logic       [5:0] sub_flags;

  sbx_alu_if alu_bus ();

  sbx_alu u_alu (
    .p (alu_bus.alu)
  );

  // ==========================================================
  // Operand selection
  assign op   = sbx_pkg::sbx_op_t'(exec_op_i);
  assign take = exec_valid_i && (state_q == ST_RUN);
  assign is_sub = (op == sbx_pkg::OP_SUB_BORROW_IMM) ||
                  (op == sbx_pkg::OP_SUB_BORROW_TO_MEM);

  always_comb begin
    if (is_sub) begin
      alu_bus.a        = acc_q;
      alu_bus.carry_in = flags_q[sbx_pkg::F_C];
      if (op == sbx_pkg::OP_SUB_BORROW_IMM) begin
        alu_bus.b = exec_imm_i;
      end else begin
        alu_bus.b = mem_rdata_i;
      end
    end else begin
      alu_bus.a        = mem_rdata_i;
      alu_bus.b        = sbx_pkg::DEC_STEP;
      alu_bus.carry_in = 1'b1;
    end
  end

  assign zero = (alu_bus.diff == 8'h00);
  assign skip_hit = take && !is_sub && zero;

  always_comb begin
    sub_flags                      = 6'h00;
    sub_flags[sbx_pkg::F_C]        = alu_bus.carry_out;
    sub_flags[sbx_pkg::F_AC]       = alu_bus.half_carry;
    sub_flags[sbx_pkg::F_Z]        = zero;
    sub_flags[sbx_pkg::F_OV]       = alu_bus.arith_wrap_flag;
    sub_flags[sbx_pkg::F_SC]       = alu_bus.signed_carry;
    sub_flags[sbx_pkg::F_CZ]       = zero & flags_q[sbx_pkg::F_Z];
  end

  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_q &&
                 wb_sel_i[0];

  // ==========================================================
  // Skip sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_RUN;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (take && !is_sub && zero) begin
            state_q <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_q      <= 1'b0;
      last_skip_q <= 1'b0;
    end else begin
      skip_q <= take && !is_sub && zero;
      if (take && !is_sub) begin
        last_skip_q <= zero;
      end
    end
  end

  // ==========================================================
  // Accumulator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= sbx_pkg::ACC_RST;
    end else if (take && (op == sbx_pkg::OP_SUB_BORROW_IMM ||
                          op == sbx_pkg::OP_DEC_SKIP_ZERO_TO_ACC)) begin
      acc_q <= alu_bus.diff;
    end else if (wb_wr && wb_adr_i == sbx_pkg::ADDR_ACC) begin
      acc_q <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= sbx_pkg::FLAG_RST;
    end else if (take && is_sub) begin
      flags_q <= sub_flags;
    end else if (wb_wr && wb_adr_i == sbx_pkg::ADDR_STATUS) begin
      flags_q <= wb_dat_i[5:0];
    end
  end

  // ==========================================================
  // Data memory write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_we_q    <= 1'b0;
      mem_wdata_q <= 8'h00;
    end else begin
      mem_we_q <= take && (op == sbx_pkg::OP_SUB_BORROW_TO_MEM ||
                           op == sbx_pkg::OP_DEC_SKIP_ZERO);
      if (take) begin
        mem_wdata_q <= alu_bus.diff;
      end
    end
  end

  // ==========================================================
  // Wishbone read and acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0000_0000;
    end else begin
      wb_ack_q <= wb_cyc_i && wb_stb_i && !wb_ack_q;
      unique case (wb_adr_i)
        sbx_pkg::ADDR_ACC:    wb_dat_q <= {24'h000000, acc_q};
        sbx_pkg::ADDR_STATUS: wb_dat_q <= {26'h0, flags_q};
        sbx_pkg::ADDR_INFO:   wb_dat_q <= {30'h0, last_skip_q,
                                           state_q == ST_DUMMY};
        default:              wb_dat_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Ready and dummy-cycle outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b1;
      dummy_q <= 1'b0;
    end else begin
      ready_q <= !skip_hit;
      dummy_q <= skip_hit;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o     = wb_ack_q;
  assign wb_dat_o     = wb_dat_q;
  assign exec_ready_o = ready_q;
  assign mem_we_o     = mem_we_q;
  assign mem_wdata_o  = mem_wdata_q;
  assign skip_o       = skip_q;
  assign dummy_o      = dummy_q;
  assign acc_o        = acc_q;
  assign flags_o      = flags_q;
endmodule

// ### verilog/sbx_pkg.sv
// Constants and types shared by the subtract and decrement-skip datapath
package sbx_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned DW = 8;
  localparam int unsigned FW = 6;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [3:0] ADDR_ACC    = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_INFO   = 4'h8;

  // ==========================================================
  // Status field positions
  localparam int unsigned F_C  = 0;
  localparam int unsigned F_AC = 1;
  localparam int unsigned F_Z  = 2;
  localparam int unsigned F_OV = 3;
  localparam int unsigned F_SC = 4;
  localparam int unsigned F_CZ = 5;

  // ==========================================================
  // Info field positions
  localparam int unsigned I_BUSY = 0;
  localparam int unsigned I_SKIP = 1;

  // ==========================================================
  // Reset values and decrement step
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [5:0] FLAG_RST  = 6'h00;
  localparam logic [7:0] DEC_STEP  = 8'h01;

  // ==========================================================
  // Operations
  typedef enum logic [1:0] {
    OP_SUB_BORROW_IMM,
    OP_SUB_BORROW_TO_MEM,
    OP_DEC_SKIP_ZERO,
    OP_DEC_SKIP_ZERO_TO_ACC
  } sbx_op_t;
endpackage
